// File: logic/rtc_general_config_reg.sv
// rtc general configuration register with time keeping behind apb
//
// Contract
// - inhibit clear: one update every second
// - inhibit set aborts and blocks updates
// - inhibit, format, hour style, shift survive resets
// - periodic enable raises irq at rate; resume clears
// - alarm enable raises irq on alarm; battery clears
// - alarm recurs per second, hour, day, month
// - update-end enable raises irq; resume clears
// - compat wave bit is storage only
// - data format: one binary, zero bcd
// - hour style: one 24h; 12h bit7 pm
// - april first sunday 1:59:59 jumps to 3:00:00
// - october last sunday 1:59:59 back to 1:00:00
// - shift disabled means no special hour changes
// - combined flag from flags and enables drives irq
// - flag read clears flags; resume reset clears periodic and update-end flags
// - rate select zero gives no periodic flag
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module rtc_general_config_reg
  import rtc_pkg::*;
#(
  parameter int TICK_DIV = TICK_DIV_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic resume_reset_b,
  input wire logic battery_well_reset_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_b
);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [PRE_W-1:0] pre;
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [2:0] dow;
    logic [4:0] date;
    logic [3:0] mon;
    logic [6:0] year;
    logic [7:0] asec;
    logic [7:0] amin;
    logic [7:0] ahour;
    logic [5:0] adate;
    logic [3:0] rs;
    logic [7:0] cfg;
    logic pf;
    logic af;
    logic uf;
    logic upd;
    logic dst_done;
    logic [2:0] rep;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq_b;
  } state_t;

  state_t q;
  state_t d;

  function automatic logic [7:0] to_fmt(input logic [6:0] v,
                                        input logic bin);
    to_fmt = bin ? {1'b0, v} : {4'(v / BCD_BASE), 4'(v % BCD_BASE)};
  endfunction

  function automatic logic [6:0] from_fmt(input logic [7:0] b,
                                          input logic bin);
    from_fmt = bin ? b[6:0]
      : 7'({3'h0, b[7:4]} * BCD_BASE + {3'h0, b[3:0]});
  endfunction

  function automatic logic [7:0] hour_out(input logic [4:0] h,
                                          input logic [7:0] c);
    logic [4:0] h12;
    logic [7:0] t;
    h12 = (h >= HALF_DAY) ? h - HALF_DAY : h;
    if (h12 == '0) begin
      h12 = HALF_DAY;
    end
    t = to_fmt(7'(h12), c[B_FMT]);
    hour_out = c[B_HOUR] ? to_fmt(7'(h), c[B_FMT])
      : {h >= HALF_DAY, t[6:0]};
  endfunction

  function automatic logic [4:0] hour_in(input logic [7:0] b,
                                         input logic [7:0] c);
    logic [4:0] v;
    v = 5'(from_fmt({1'b0, b[6:0]}, c[B_FMT]));
    if (c[B_HOUR]) begin
      hour_in = 5'(from_fmt(b, c[B_FMT]));
    end else begin
      hour_in = ((v == HALF_DAY) ? 5'h00 : v)
        + (b[7] ? HALF_DAY : 5'h00);
    end
  endfunction

  function automatic logic [4:0] mdays(input logic [3:0] m,
                                       input logic [6:0] y);
    if (m == FEBRUARY) begin
      mdays = (y[1:0] == 2'h0) ? FEB_LEAP : FEB_NORM;
    end else if (m == APRIL || m == JUNE || m == SEPTEMBER
                 || m == NOVEMBER) begin
      mdays = DAYS_SHORT;
    end else begin
      mdays = DAYS_LONG;
    end
  endfunction

  function automatic logic per_hit(input logic [PRE_W-1:0] p,
                                   input logic [3:0] r);
    logic [3:0] k;
    logic [PRE_W-1:0] m;
    k = (r < RS_SLOW_LIM) ? r + RS_SLOW_ADD : r - 4'h1;
    m = (15'h0001 << k) - 15'h0001;
    per_hit = (r != '0) && ((p & m) == '0);
  endfunction

  function automatic logic combined_irq_flag(input logic pf, input logic af,
                                input logic uf, input logic [7:0] c);
    combined_irq_flag = (pf && c[B_PIE]) || (af && c[B_AIE])
      || (uf && c[B_UIE]);
  endfunction

  logic [5:0] idx;
  logic tick;
  logic wrap;
  logic setup;
  logic done;
  logic abort;
  logic alarm_hit;
  logic dst_at;

  assign idx = paddr[7:2];
  assign tick = (q.div == DIV_W'(TICK_DIV - 1));
  assign wrap = tick && (q.pre == '1);
  assign setup = psel && !penable;
  assign done = psel && penable && q.pready;
  assign abort = done && pwrite && idx == IDX_B
    && pwdata[B_INHIBIT];
  // a seconds, minutes or hours field whose top two bits are set matches any value; a zero date matches any date
  assign alarm_hit =
    (q.asec[7:6] == DONT_CARE
     || q.asec == to_fmt(7'(q.sec), q.cfg[B_FMT]))
    && (q.amin[7:6] == DONT_CARE
     || q.amin == to_fmt(7'(q.min), q.cfg[B_FMT]))
    && (q.ahour[7:6] == DONT_CARE
     || q.ahour == hour_out(q.hour, q.cfg))
    && (q.adate == '0
     || {2'h0, q.adate} == to_fmt(7'(q.date), q.cfg[B_FMT]));
  assign dst_at = q.cfg[B_DST] && q.dow == SUNDAY
    && q.hour == DST_HOUR && q.min == LAST_MS
    && q.sec == LAST_MS;

  always_comb begin
    logic [7:0] rdv;
    rdv = '0;
    d = q;
    // prescaler stands in for the 32 khz divider chain
    d.div = tick ? '0 : q.div + 1'b1;
    if (tick) begin
      d.pre = q.pre + 1'b1;
    end
    d.upd = wrap && !q.cfg[B_INHIBIT] && !abort;
    if (d.upd) begin
      if (dst_at && q.mon == APRIL && q.date <= FIRST_SUN_MAX) begin
        d.hour = SPRING_HOUR;
        d.min = '0;
        d.sec = '0;
      end else if (dst_at && q.mon == OCTOBER
                   && q.date >= LAST_SUN_MIN && !q.dst_done) begin
        d.hour = DST_HOUR;
        d.min = '0;
        d.sec = '0;
        d.dst_done = 1'b1;
      end else if (q.sec != LAST_MS) begin
        d.sec = q.sec + 1'b1;
      end else begin
        d.sec = '0;
        if (q.min != LAST_MS) begin
          d.min = q.min + 1'b1;
        end else begin
          d.min = '0;
          if (q.hour != LAST_HOUR) begin
            d.hour = q.hour + 1'b1;
          end else begin
            d.hour = '0;
            d.dst_done = 1'b0;
            d.dow = (q.dow == LAST_DOW) ? SUNDAY : q.dow + 1'b1;
            if (q.date != mdays(q.mon, q.year)) begin
              d.date = q.date + 1'b1;
            end else begin
              d.date = FIRST_DAY;
              if (q.mon != LAST_MON) begin
                d.mon = q.mon + 1'b1;
              end else begin
                d.mon = FIRST_MON;
                d.year = (q.year == LAST_YEAR) ? '0 : q.year + 1'b1;
              end
            end
          end
        end
      end
    end
    unique case (idx)
      IDX_SEC: rdv = to_fmt(7'(q.sec), q.cfg[B_FMT]);
      IDX_ASEC: rdv = q.asec;
      IDX_MIN: rdv = to_fmt(7'(q.min), q.cfg[B_FMT]);
      IDX_AMIN: rdv = q.amin;
      IDX_HOUR: rdv = hour_out(q.hour, q.cfg);
      IDX_AHOUR: rdv = q.ahour;
      IDX_DOW: rdv = to_fmt(7'(q.dow), q.cfg[B_FMT]);
      IDX_DATE: rdv = to_fmt(7'(q.date), q.cfg[B_FMT]);
      IDX_MON: rdv = to_fmt(7'(q.mon), q.cfg[B_FMT]);
      IDX_YEAR: rdv = to_fmt(q.year, q.cfg[B_FMT]);
      IDX_A: rdv = {4'h0, q.rs};
      IDX_B: rdv = q.cfg;
      IDX_C: rdv = {combined_irq_flag(q.pf, q.af, q.uf, q.cfg), q.pf, q.af, q.uf,
                    4'h0};
      IDX_D: rdv = {D_TOP, q.adate};
      default: rdv = '0;
    endcase
    if (setup) begin
      d.pready = 1'b1;
      d.pslverr = idx > IDX_D;
      d.prdata = pwrite ? '0 : {24'h00_0000, rdv};
      // only flags that were reported get cleared on completion
      d.rep = (!pwrite && idx == IDX_C) ? {q.pf, q.af, q.uf} : '0;
    end
    if (done) begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      if (pwrite && !q.pslverr) begin
        unique case (idx)
          IDX_SEC: d.sec = 6'(from_fmt(pwdata[7:0], q.cfg[B_FMT]));
          IDX_ASEC: d.asec = pwdata[7:0];
          IDX_MIN: d.min = 6'(from_fmt(pwdata[7:0], q.cfg[B_FMT]));
          IDX_AMIN: d.amin = pwdata[7:0];
          IDX_HOUR: d.hour = hour_in(pwdata[7:0], q.cfg);
          IDX_AHOUR: d.ahour = pwdata[7:0];
          IDX_DOW: d.dow = 3'(from_fmt(pwdata[7:0], q.cfg[B_FMT]));
          IDX_DATE: d.date = 5'(from_fmt(pwdata[7:0], q.cfg[B_FMT]));
          IDX_MON: d.mon = 4'(from_fmt(pwdata[7:0], q.cfg[B_FMT]));
          IDX_YEAR: d.year = from_fmt(pwdata[7:0], q.cfg[B_FMT]);
          IDX_A: d.rs = pwdata[3:0];
          IDX_B: d.cfg = pwdata[7:0];
          IDX_D: d.adate = pwdata[5:0];
          default: d.rs = q.rs;
        endcase
      end
      d.pf = q.pf && !q.rep[2];
      d.af = q.af && !q.rep[1];
      d.uf = q.uf && !q.rep[0];
      d.rep = '0;
    end
    // sets come after the read clear so a coincident event survives
    d.pf = d.pf || (tick && per_hit(d.pre, q.rs));
    d.uf = d.uf || d.upd;
    d.af = d.af || (q.upd && alarm_hit);
    if (!resume_reset_b) begin
      d.cfg[B_PIE] = 1'b0;
      d.cfg[B_UIE] = 1'b0;
      d.cfg[B_WAVE] = 1'b0;
      d.pf = 1'b0;
      d.uf = 1'b0;
    end
    if (!battery_well_reset_b) begin
      d.cfg[B_AIE] = 1'b0;
      d.af = 1'b0;
      d.rs = '0;
      d.sec = '0;
      d.min = '0;
      d.hour = '0;
      d.dow = SUNDAY;
      d.date = FIRST_DAY;
      d.mon = FIRST_MON;
      d.year = '0;
      d.asec = '0;
      d.amin = '0;
      d.ahour = '0;
      d.adate = '0;
      d.dst_done = 1'b0;
    end
    d.irq_b = !combined_irq_flag(d.pf, d.af, d.uf, d.cfg);
    // inhibit, format, hour style and shift bits are never reset
    if (!rst_b) begin
      d.div = '0;
      d.pre = '0;
      d.upd = 1'b0;
      d.rep = '0;
      d.prdata = '0;
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      d.irq_b = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq_b = q.irq_b;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  update_run_a: assert property (
    wrap && !q.cfg[B_INHIBIT] && !abort |=> q.upd)
    else $error("second boundary without update");
  update_hold_a: assert property (
    q.cfg[B_INHIBIT] || abort |=> !q.upd)
    else $error("update ran while inhibited");
  // these bits stay unknown until written, so compare by stability
  cfg_keep_a: assert property (
    !(done && pwrite && idx == IDX_B) |=>
      $stable({q.cfg[B_INHIBIT], q.cfg[B_FMT], q.cfg[B_HOUR],
               q.cfg[B_DST]}))
    else $error("persistent config bit changed");
  alarm_set_a: assert property (
    q.upd && alarm_hit && battery_well_reset_b |=> q.af)
    else $error("alarm match did not set flag");
  uend_set_a: assert property (
    q.upd |-> q.uf || !$past(resume_reset_b))
    else $error("update end flag missing");
  // irq_b is registered with the flags, so both move at one edge
  irq_level_a: assert property (
    combined_irq_flag(q.pf, q.af, q.uf, q.cfg) && $past(rst_b) |-> !irq_b)
    else $error("combined flag without irq");
  irq_idle_a: assert property (
    !combined_irq_flag(q.pf, q.af, q.uf, q.cfg) |-> irq_b)
    else $error("irq without combined flag");
  flag_read_a: assert property (
    done && !pwrite && idx == IDX_C && q.rep[0] && !wrap |=> !q.uf)
    else $error("flag read did not clear");
  rate_zero_a: assert property (
    q.rs == '0 && !q.pf |=> !q.pf)
    else $error("periodic flag with rate zero");
  resume_clr_a: assert property (
    !resume_reset_b |=> !q.cfg[B_PIE] && !q.cfg[B_UIE]
      && !q.cfg[B_WAVE] && !q.pf && !q.uf)
    else $error("resume reset left bits set");

endmodule

// File: logic/rtc_pkg.sv
// constants for the rtc configuration register block
package rtc_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_SEC = 6'h00;
  localparam logic [5:0] IDX_ASEC = 6'h01;
  localparam logic [5:0] IDX_MIN = 6'h02;
  localparam logic [5:0] IDX_AMIN = 6'h03;
  localparam logic [5:0] IDX_HOUR = 6'h04;
  localparam logic [5:0] IDX_AHOUR = 6'h05;
  localparam logic [5:0] IDX_DOW = 6'h06;
  localparam logic [5:0] IDX_DATE = 6'h07;
  localparam logic [5:0] IDX_MON = 6'h08;
  localparam logic [5:0] IDX_YEAR = 6'h09;
  localparam logic [5:0] IDX_A = 6'h0a;
  localparam logic [5:0] IDX_B = 6'h0b;
  localparam logic [5:0] IDX_C = 6'h0c;
  localparam logic [5:0] IDX_D = 6'h0d;
  // general configuration bits
  localparam int B_INHIBIT = 7;
  localparam int B_PIE = 6;
  localparam int B_AIE = 5;
  localparam int B_UIE = 4;
  localparam int B_WAVE = 3;
  localparam int B_FMT = 2;
  localparam int B_HOUR = 1;
  localparam int B_DST = 0;
  // fixed read value of bits 7:6 of the date-alarm register, then the alarm don't-care pattern for bits 7:6
  localparam logic [1:0] D_TOP = 2'h2;
  localparam logic [1:0] DONT_CARE = 2'h3;
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_HZ = 32_768;
  localparam int TICK_DIV_DEF = (CLK_HZ + TICK_HZ / 2) / TICK_HZ;
  localparam int DIV_W = 12;
  localparam int PRE_W = 15;
  localparam logic [3:0] RS_SLOW_LIM = 4'h3;
  localparam logic [3:0] RS_SLOW_ADD = 4'h6;
  // calendar
  localparam logic [6:0] BCD_BASE = 7'h0a;
  localparam logic [5:0] LAST_MS = 6'h3b;
  localparam logic [4:0] LAST_HOUR = 5'h17;
  localparam logic [4:0] HALF_DAY = 5'h0c;
  localparam logic [2:0] SUNDAY = 3'h1;
  localparam logic [2:0] LAST_DOW = 3'h7;
  localparam logic [4:0] FIRST_DAY = 5'h01;
  localparam logic [3:0] FIRST_MON = 4'h1;
  localparam logic [3:0] LAST_MON = 4'hc;
  localparam logic [6:0] LAST_YEAR = 7'h63;
  localparam logic [3:0] FEBRUARY = 4'h2;
  localparam logic [3:0] APRIL = 4'h4;
  localparam logic [3:0] JUNE = 4'h6;
  localparam logic [3:0] SEPTEMBER = 4'h9;
  localparam logic [3:0] OCTOBER = 4'ha;
  localparam logic [3:0] NOVEMBER = 4'hb;
  localparam logic [4:0] DAYS_LONG = 5'h1f;
  localparam logic [4:0] DAYS_SHORT = 5'h1e;
  localparam logic [4:0] FEB_LEAP = 5'h1d;
  localparam logic [4:0] FEB_NORM = 5'h1c;
  // daylight shift moments
  localparam logic [4:0] DST_HOUR = 5'h01;
  localparam logic [4:0] SPRING_HOUR = 5'h03;
  localparam logic [4:0] FIRST_SUN_MAX = 5'h07;
  localparam logic [4:0] LAST_SUN_MIN = 5'h19;
endpackage

// File: sim/tb.sv
// self-checking bench for the rtc general configuration register
`timescale 1ns/1ps
`define chk(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("[ERR] %0t got %h want %h", $time, got, exp); \
    end \
  end
module tb;
  import rtc_pkg::*;
  // divide by one makes every clock a tick: a second is 32768 clocks
  localparam int TDIV = 1;
  localparam int SEC_CLKS = 32768 * TDIV;
  logic clk;
  logic rst_b;
  logic resume_reset_b;
  logic battery_well_reset_b;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic pready;
  logic pslverr;
  logic rerr;
  logic irq_b;
  int fails = 0;
  int n_checks = 0;

  rtc_general_config_reg #(.TICK_DIV(TDIV)) uut (
    .clk(clk),
    .rst_b(rst_b),
    .resume_reset_b(resume_reset_b),
    .battery_well_reset_b(battery_well_reset_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq_b(irq_b)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic complete_run();
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one apb transfer; the master never assumes the slave's latency
  task automatic apb(input logic wr, input logic [5:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      $display("[ERR] %0t no pready", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [5:0] idx);
    apb(1'b0, idx, 8'h00);
  endtask

  // drives the selected resets low for five clocks; 0 selects a reset
  task automatic pulse(input logic r0, input logic r1, input logic r2);
    @(posedge clk);
    rst_b <= r0;
    resume_reset_b <= r1;
    battery_well_reset_b <= r2;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    resume_reset_b <= 1'b1;
    battery_well_reset_b <= 1'b1;
  endtask

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq_b !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  // each well reset clears only its own bits
  task automatic t_resets();
    wr(IDX_B, 8'hff);
    rd(IDX_B);
    `chk(rdat, 32'h0000_00ff)
    pulse(1'b1, 1'b0, 1'b1);
    rd(IDX_B);
    `chk(rdat[7:0], 8'ha7)
    wr(IDX_B, 8'hff);
    pulse(1'b1, 1'b1, 1'b0);
    rd(IDX_B);
    `chk(rdat[7:0], 8'hdf)
    pulse(1'b0, 1'b1, 1'b1);
    rd(IDX_B);
    `chk(rdat[7:0], 8'hdf)
  endtask

  // unmapped index refused; rate zero gives no periodic flag
  task automatic t_refuse();
    rd(6'h0e);
    `chk(rerr, 1'b1)
    `chk(rdat, 32'h0000_0000)
    wr(IDX_C, 8'hff);
    rd(IDX_C);
    `chk(rerr, 1'b0)
    `chk(rdat[7:0], 8'h00)
    `chk(irq_b, 1'b1)
  endtask

  // periodic enable set since the battery reset left it alone
  task automatic t_periodic();
    wr(IDX_A, 8'h03);
    wait_irq(40);
    `chk(irq_b, 1'b0)
    wr(IDX_A, 8'h00);
    rd(IDX_C);
    `chk(rdat[7:0], 8'hc0)
    repeat (2) @(posedge clk);
    `chk(irq_b, 1'b1)
    rd(IDX_C);
    `chk(rdat[7:0], 8'h00)
  endtask

  // a full second passes with the inhibit bit held
  task automatic t_inhibit();
    wr(IDX_B, 8'h86);
    // a sunday in april at 1:59:59; alarm hour set to don't care
    wr(IDX_SEC, 8'h3b);
    wr(IDX_MIN, 8'h3b);
    wr(IDX_HOUR, 8'h01);
    wr(IDX_MON, 8'h04);
    wr(IDX_AHOUR, 8'hc0);
    repeat (SEC_CLKS + 200) @(posedge clk);
    rd(IDX_SEC);
    `chk(rdat[7:0], 8'h3b)
    rd(IDX_C);
    `chk(rdat[7:0], 8'h00)
  endtask

  // block reset restarts the prescaler but keeps the config
  task automatic t_update();
    pulse(1'b0, 1'b1, 1'b1);
    rd(IDX_B);
    `chk(rdat[7:0], 8'h86)
    // shift bit off at the april moment, so no settling updates owed
    wr(IDX_B, 8'h16);
    wait_irq(SEC_CLKS + 100);
    `chk(irq_b, 1'b0)
    rd(IDX_SEC);
    `chk(rdat[7:0], 8'h00)
    rd(IDX_HOUR);
    `chk(rdat[7:0], 8'h02)
    rd(IDX_C);
    `chk(rdat[7:0], 8'hb0)
    repeat (2) @(posedge clk);
    `chk(irq_b, 1'b1)
  endtask

  initial begin
    rst_b = 1'b0;
    resume_reset_b = 1'b0;
    battery_well_reset_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    resume_reset_b <= 1'b1;
    battery_well_reset_b <= 1'b1;
    t_resets();
    t_refuse();
    t_periodic();
    t_inhibit();
    t_update();
    complete_run();
  end

  initial begin
    repeat (3 * SEC_CLKS) @(posedge clk);
    fails++;
    complete_run();
  end
endmodule
